// file: pingpong_consts.vh
`ifndef PINGPONG_CONSTS_VH
`define PINGPONG_CONSTS_VH

// clock rate and time figures
`define CLK_KHZ           40000
`define TIMEOUT_MS        1000
`define BLINK_HALF_MS     500
`define BLINK_PERIODS     4'h4
`define INIT_CYCLES       8'h10

// register offsets (byte addresses)
`define REG_STATUS        8'h00
`define REG_MASK          8'h04
`define REG_CONFIG        8'h08
`define REG_ERR_COUNT     8'h0C
`define REG_FRAME_COUNT   8'h10
`define REG_CONTROL       8'h14

// status and mask bit positions
`define ST_TIMEOUT        0
`define ST_MISMATCH       1
`define ST_CTRL_ERR       2
`define ST_BUS_OFF        3
`define ST_RX_FRAME       4
`define ST_TX_DONE        5
`define ST_WIDTH          6

// config register fields
`define CFG_ROLE          0
`define CFG_PATTERN       1
`define CFG_RATE_LO       2
`define CFG_RATE_HI       3
`define CFG_BOOT_NVM      4
`define CFG_DONE          5

// control register fields
`define CTL_CLR_COUNTS    0

// reset values
`define STATUS_RESET      6'h00
`define MASK_RESET        6'h00

// payload patterns
`define PATTERN_ALT       32'h55555555
`define PATTERN_ZERO      32'h00000000

// bit rate codes {rate_strap_high, rate_strap_low}
`define RATE_125K         2'h0
`define RATE_250K         2'h1
`define RATE_500K         2'h2
`define RATE_1000K        2'h3

`endif

// file: strap_sync.v
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
    parameter WIDTH = 6
) (
    input  wire             clk_sys_in,
    input  wire             rst_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    // two flops per pin; the first stage feeds only the second
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            always @(posedge clk_sys_in) begin
                if (rst_in) begin
                    meta_q   <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q   <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate

endmodule

`default_nettype wire

// file: blink_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "pingpong_consts.vh"

module blink_sequencer #(
    parameter [31:0] HALF_CYCLES = 32'd20000000
) (
    input  wire clk_sys_in,
    input  wire rst_in,
    input  wire start_in,
    output wire led_out,
    output wire busy_out
);

    reg [31:0] half_cnt_q;
    reg [3:0]  halves_q;
    reg        led_q;

    // runs beside the exchange; a new start restarts the four periods
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            half_cnt_q <= 32'h00000000;
            halves_q   <= 4'h0;
            led_q      <= 1'b0;
        end else if (start_in) begin
            half_cnt_q <= HALF_CYCLES - 32'h00000001;
            halves_q   <= (`BLINK_PERIODS << 1) - 4'h1;
            led_q      <= 1'b1;
        end else if (led_q || halves_q != 4'h0) begin
            if (half_cnt_q == 32'h00000000) begin
                half_cnt_q <= HALF_CYCLES - 32'h00000001;
                if (halves_q != 4'h0) begin
                    halves_q <= halves_q - 4'h1;
                    led_q    <= ~led_q;
                end else begin
                    led_q    <= 1'b0;
                end
            end else begin
                half_cnt_q <= half_cnt_q - 32'h00000001;
            end
        end
    end

    assign led_out  = led_q;
    assign busy_out = led_q | (halves_q != 4'h0);

endmodule

`default_nettype wire

// file: can_link_pingpong_tester.v
`timescale 1ns/1ps
`default_nettype none
`include "pingpong_consts.vh"

module can_link_pingpong_tester #(
    parameter [31:0] TIMEOUT_CYCLES    = `TIMEOUT_MS * `CLK_KHZ,
    parameter [31:0] BLINK_HALF_CYCLES = `BLINK_HALF_MS * `CLK_KHZ
) (
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        pattern_select_strap_in,
    input  wire        role_select_strap_in,
    input  wire        rate_strap_high_in,
    input  wire        rate_strap_low_in,
    input  wire        boot_strap_a_in,
    input  wire        boot_strap_b_in,
    output wire        boot_from_nvm_out,
    output wire        can_cfg_valid_out,
    output wire [1:0]  can_rate_sel_out,
    output wire        tx_req_out,
    output wire [31:0] tx_data_out,
    input  wire        tx_done_in,
    input  wire        rx_valid_in,
    input  wire [31:0] rx_data_in,
    input  wire        ctrl_error_in,
    input  wire        ctrl_bus_off_in,
    output wire        error_led_out,
    output wire        bus_off_led_out,
    output wire        master_led_out,
    output wire        irq_out,
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output wire [31:0] reg_rdata_out
);

    localparam [3:0] ST_INIT   = 4'h0;
    localparam [3:0] ST_STRAP  = 4'h1;
    localparam [3:0] ST_PROG   = 4'h2;
    localparam [3:0] ST_M_SEND = 4'h3;
    localparam [3:0] ST_M_WAIT = 4'h4;
    localparam [3:0] ST_S_WAIT = 4'h5;
    localparam [3:0] ST_S_SEND = 4'h6;
    localparam [3:0] ST_CHECK  = 4'h7;

    wire [5:0] straps_sync;
    wire       pattern_s;
    wire       role_s;
    wire       rate_hi_s;
    wire       rate_lo_s;
    wire       boot_a_s;
    wire       boot_b_s;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [7:0]  init_cnt_q;
    reg         role_q;
    reg         pattern_q;
    reg  [1:0]  rate_q;
    reg         boot_nvm_q;
    reg         cfg_done_q;
    reg         cfg_valid_q;
    reg         tx_req_q;
    reg  [31:0] tx_data_q;
    reg  [31:0] rx_data_q;
    reg         rx_err_q;
    reg  [31:0] timer_q;
    reg         timer_run_q;
    reg         bus_off_prev_q;
    reg  [15:0] err_cnt_q;
    reg  [15:0] frame_cnt_q;
    reg  [5:0]  status_q;
    reg  [5:0]  mask_q;
    reg         irq_q;
    reg  [31:0] rdata_q;
    reg         master_led_q;

    wire        timer_expired;
    wire        start_timer;
    wire        ev_timeout;
    wire        ev_mismatch;
    wire        ev_ctrl_err;
    wire        ev_bus_off;
    wire        ev_rx;
    wire        ev_tx_done;
    wire        any_error;
    wire        rx_accept;
    wire        wr_status;
    wire        wr_mask;
    wire        clr_counts;
    wire [31:0] expected;
    wire [5:0]  events;
    wire [5:0]  status_d;

    // pins come from outside the clock domain
    strap_sync #(
        .WIDTH (6)
    ) u_strap_sync (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .async_in   ({boot_strap_b_in, boot_strap_a_in, rate_strap_low_in,
                      rate_strap_high_in, role_select_strap_in, pattern_select_strap_in}),
        .sync_out   (straps_sync)
    );

    assign pattern_s = straps_sync[0];
    assign role_s    = straps_sync[1];
    assign rate_hi_s = straps_sync[2];
    assign rate_lo_s = straps_sync[3];
    assign boot_a_s  = straps_sync[4];
    assign boot_b_s  = straps_sync[5];

    // payload expected on receive and sent on transmit
    assign expected = pattern_q ? `PATTERN_ZERO : `PATTERN_ALT;

    // frames are only taken while waiting; frames arriving in any other state are ignored
    assign rx_accept = rx_valid_in && (state_q == ST_M_WAIT || state_q == ST_S_WAIT);

    assign timer_expired = timer_run_q && (timer_q == 32'h00000000) && !rx_valid_in;

    // timer loads after each sent frame; slave also reloads on expiry
    assign start_timer = (tx_req_q && tx_done_in)
                       || (state_q == ST_S_WAIT && timer_expired);

    // sequence control
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_INIT: begin
                if (init_cnt_q == `INIT_CYCLES) begin
                    state_d = ST_STRAP;
                end
            end
            ST_STRAP: begin
                state_d = ST_PROG;
            end
            ST_PROG: begin
                state_d = role_q ? ST_M_SEND : ST_S_WAIT;
            end
            ST_M_SEND: begin
                if (tx_req_q && tx_done_in) begin
                    state_d = ST_M_WAIT;
                end
            end
            ST_M_WAIT: begin
                if (rx_accept) begin
                    state_d = ST_CHECK;
                end else if (timer_expired) begin
                    state_d = ST_M_SEND;
                end
            end
            ST_S_WAIT: begin
                if (rx_accept) begin
                    state_d = ST_CHECK;
                end
            end
            ST_S_SEND: begin
                if (tx_req_q && tx_done_in) begin
                    state_d = ST_S_WAIT;
                end
            end
            ST_CHECK: begin
                state_d = role_q ? ST_M_SEND : ST_S_SEND;
            end
            default: begin
                state_d = ST_INIT;
            end
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_q <= ST_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // init delay also lets the strap synchronisers fill
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            init_cnt_q <= 8'h00;
        end else if (state_q == ST_INIT && init_cnt_q != `INIT_CYCLES) begin
            init_cnt_q <= init_cnt_q + 8'h01;
        end
    end

    // straps latched once; only a reset can sample them again
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            role_q     <= 1'b0;
            pattern_q  <= 1'b0;
            rate_q     <= `RATE_125K;
            boot_nvm_q <= 1'b0;
            cfg_done_q <= 1'b0;
        end else if (state_q == ST_STRAP && !cfg_done_q) begin
            role_q     <= role_s;
            pattern_q  <= pattern_s;
            rate_q     <= {rate_hi_s, rate_lo_s};
            boot_nvm_q <= boot_a_s & boot_b_s;
            cfg_done_q <= 1'b1;
        end
    end

    // controller programming pulse and master indicator
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_valid_q  <= 1'b0;
            master_led_q <= 1'b0;
        end else begin
            cfg_valid_q  <= (state_q == ST_PROG);
            master_led_q <= cfg_done_q & role_q;
        end
    end

    // transmit request held until the controller acknowledges it
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            tx_req_q  <= 1'b0;
            tx_data_q <= 32'h00000000;
        end else if (tx_req_q) begin
            if (tx_done_in) begin
                tx_req_q <= 1'b0;
            end
        end else if (state_q == ST_M_SEND || state_q == ST_S_SEND) begin
            tx_req_q  <= 1'b1;
            tx_data_q <= expected;
        end
    end

    // capture frame and controller error state at arrival
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            rx_data_q <= 32'h00000000;
            rx_err_q  <= 1'b0;
        end else if (rx_accept) begin
            rx_data_q <= rx_data_in;
            rx_err_q  <= ctrl_error_in | ctrl_bus_off_in;
        end
    end

    // one-second countdown; stops once a frame is taken
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            timer_q     <= 32'h00000000;
            timer_run_q <= 1'b0;
        end else if (start_timer) begin
            timer_q     <= TIMEOUT_CYCLES - 32'h00000001;
            timer_run_q <= 1'b1;
        end else if (rx_accept || (state_q == ST_M_WAIT && timer_expired)) begin
            timer_run_q <= 1'b0;
        end else if (timer_run_q && timer_q != 32'h00000000) begin
            timer_q <= timer_q - 32'h00000001;
        end
    end

    // rising edge of bus-off only; bus-off seen at a checked frame counts as a controller error
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            bus_off_prev_q <= 1'b0;
        end else begin
            bus_off_prev_q <= ctrl_bus_off_in;
        end
    end

    assign ev_timeout  = timer_expired && (state_q == ST_M_WAIT || state_q == ST_S_WAIT);
    assign ev_mismatch = (state_q == ST_CHECK) && (rx_data_q != expected);
    assign ev_ctrl_err = (state_q == ST_CHECK) && rx_err_q;
    assign ev_bus_off  = ctrl_bus_off_in && !bus_off_prev_q;
    assign ev_rx       = rx_accept;
    assign ev_tx_done  = tx_req_q && tx_done_in;
    assign any_error   = ev_timeout | ev_mismatch | ev_ctrl_err;

    // error and frame counters, saturating; software may clear them
    assign clr_counts = reg_wr_in && (reg_addr_in == `REG_CONTROL) && reg_wdata_in[`CTL_CLR_COUNTS];

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            err_cnt_q   <= 16'h0000;
            frame_cnt_q <= 16'h0000;
        end else begin
            if (any_error && err_cnt_q != 16'hFFFF) begin
                err_cnt_q <= err_cnt_q + 16'h0001;
            end else if (clr_counts) begin
                err_cnt_q <= 16'h0000;
            end
            if (ev_rx && frame_cnt_q != 16'hFFFF) begin
                frame_cnt_q <= frame_cnt_q + 16'h0001;
            end else if (clr_counts) begin
                frame_cnt_q <= 16'h0000;
            end
        end
    end

    // indicator sequencers run beside the exchange, never stalling it
    blink_sequencer #(
        .HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_error_blink (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .start_in   (any_error),
        .led_out    (error_led_out),
        .busy_out   ()
    );

    blink_sequencer #(
        .HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_bus_off_blink (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .start_in   (ev_bus_off),
        .led_out    (bus_off_led_out),
        .busy_out   ()
    );

    // sticky status; a new event beats a same-cycle write-one clear
    assign events = {ev_tx_done, ev_rx, ev_bus_off, ev_ctrl_err, ev_mismatch, ev_timeout};
    assign wr_status = reg_wr_in && (reg_addr_in == `REG_STATUS);
    assign wr_mask   = reg_wr_in && (reg_addr_in == `REG_MASK);
    assign status_d  = (status_q & ~(wr_status ? reg_wdata_in[`ST_WIDTH-1:0] : 6'h00)) | events;

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            status_q <= `STATUS_RESET;
            mask_q   <= `MASK_RESET;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            if (wr_mask) begin
                mask_q <= reg_wdata_in[`ST_WIDTH-1:0];
            end
            irq_q <= |(status_q & mask_q);
        end
    end

    // read data stand one cycle after the strobe; unmapped reads give zero
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `REG_STATUS:      rdata_q <= {26'h0000000, status_q};
                `REG_MASK:        rdata_q <= {26'h0000000, mask_q};
                `REG_CONFIG:      rdata_q <= {26'h0000000, cfg_done_q, boot_nvm_q, rate_q, pattern_q, role_q};
                `REG_ERR_COUNT:   rdata_q <= {16'h0000, err_cnt_q};
                `REG_FRAME_COUNT: rdata_q <= {16'h0000, frame_cnt_q};
                default:          rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign boot_from_nvm_out = boot_nvm_q;
    assign can_cfg_valid_out = cfg_valid_q;
    assign can_rate_sel_out  = rate_q;
    assign tx_req_out        = tx_req_q;
    assign tx_data_out       = tx_data_q;
    assign master_led_out    = master_led_q;
    assign irq_out           = irq_q;
    assign reg_rdata_out     = rdata_q;

endmodule

`default_nettype wire

// file: can_link_pingpong_tester_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pingpong_checker #(
    parameter [31:0] TIMEOUT_CYCLES    = 32'd200,
    parameter [31:0] BLINK_HALF_CYCLES = 32'd20
) (
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        pattern_select_strap_in,
    input wire logic        role_select_strap_in,
    input wire logic        can_cfg_valid_out,
    input wire logic [1:0]  can_rate_sel_out,
    input wire logic        tx_req_out,
    input wire logic [31:0] tx_data_out,
    input wire logic        tx_done_in,
    input wire logic        rx_valid_in,
    input wire logic        error_led_out,
    input wire logic        bus_off_led_out
);
    logic        seen_q, role_q, pattern_q, rx_seen_q;
    logic [7:0]  cyc_q;
    logic [31:0] idle_q, hi_q;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // straps copied at the programming pulse
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            seen_q    <= 1'b0;
            role_q    <= 1'b0;
            pattern_q <= 1'b0;
            rx_seen_q <= 1'b0;
            cyc_q     <= 8'h00;
        end else begin
            if (can_cfg_valid_out) begin
                seen_q    <= 1'b1;
                role_q    <= role_select_strap_in;
                pattern_q <= pattern_select_strap_in;
            end
            if (rx_valid_in && seen_q) rx_seen_q <= 1'b1;
            if (cyc_q != 8'hFF) cyc_q <= cyc_q + 8'h01;
        end
    end

    // idle run since last send or receive; lit width of error lamp
    always @(posedge clk_sys_in) begin
        if (rst_in || !seen_q || tx_req_out || rx_valid_in) idle_q <= 32'h0;
        else if (idle_q != 32'hFFFFFFFF) idle_q <= idle_q + 32'h1;
        if (rst_in || !error_led_out) hi_q <= 32'h0;
        else hi_q <= hi_q + 32'h1;
    end

    chk_cfg_once: assert property (can_cfg_valid_out |-> !seen_q)
        else $error("programming pulse repeated");
    chk_rate_hold: assert property (seen_q |-> $stable(can_rate_sel_out))
        else $error("rate select moved after sampling");
    chk_init_first: assert property (can_cfg_valid_out |-> cyc_q >= 8'h10)
        else $error("straps used before init finished");
    chk_cfg_bound: assert property (cyc_q == 8'h28 |-> seen_q)
        else $error("controller never programmed");
    chk_tx_hold: assert property (tx_req_out && !tx_done_in |=> tx_req_out && $stable(tx_data_out))
        else $error("send request dropped early");
    chk_tx_release: assert property (tx_req_out && tx_done_in |=> !tx_req_out)
        else $error("send request held after done");
    chk_payload_value: assert property (tx_req_out |-> tx_data_out == (pattern_q ? 32'h00000000 : 32'h55555555))
        else $error("wrong payload");
    chk_slave_quiet: assert property (seen_q && !role_q && !rx_seen_q |-> !tx_req_out)
        else $error("slave sent before any frame");
    chk_master_first: assert property (can_cfg_valid_out && role_select_strap_in |-> ##[1:10] tx_req_out)
        else $error("master did not open traffic");
    chk_master_retry: assert property (seen_q && role_q |-> idle_q <= TIMEOUT_CYCLES + 32'd8)
        else $error("master did not resend");
    chk_blink_width: assert property ($fell(error_led_out) |-> hi_q >= BLINK_HALF_CYCLES)
        else $error("error lamp lit too short");

    cov_reply: cover property (tx_req_out && tx_done_in ##[1:40] rx_valid_in);
    cov_err_blink: cover property ($rose(error_led_out));
    cov_bus_off: cover property ($rose(bus_off_led_out));
endmodule

bind can_link_pingpong_tester pingpong_checker #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) u_chk (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .pattern_select_strap_in(pattern_select_strap_in),
    .role_select_strap_in(role_select_strap_in), .can_cfg_valid_out(can_cfg_valid_out),
    .can_rate_sel_out(can_rate_sel_out), .tx_req_out(tx_req_out), .tx_data_out(tx_data_out),
    .tx_done_in(tx_done_in), .rx_valid_in(rx_valid_in), .error_led_out(error_led_out),
    .bus_off_led_out(bus_off_led_out)
);
`default_nettype wire

// file: can_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        tx_req_in,
    input  wire logic        reply_en_in,
    input  wire logic [31:0] reply_data_in,
    input  wire logic [7:0]  delay_in,
    input  wire logic        send_in,
    output logic             tx_done_out,
    output logic             rx_valid_out,
    output logic [31:0]      rx_data_out
);
    logic       busy_q, pend_q;
    logic [7:0] cnt_q, rcnt_q;

    // frame and reply each take delay_in + 1 cycles
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            busy_q       <= 1'b0;
            pend_q       <= 1'b0;
            cnt_q        <= 8'h00;
            rcnt_q       <= 8'h00;
            tx_done_out  <= 1'b0;
            rx_valid_out <= 1'b0;
            rx_data_out  <= 32'h00000000;
        end else begin
            tx_done_out  <= 1'b0;
            rx_valid_out <= 1'b0;
            rx_data_out  <= ~rx_data_out; // no stale payload
            if (tx_req_in && !tx_done_out && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= delay_in;
            end else if (busy_q && cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end else if (busy_q) begin
                busy_q      <= 1'b0;
                tx_done_out <= 1'b1;
                pend_q      <= reply_en_in;
                rcnt_q      <= delay_in;
            end
            // reply after a frame, or on command
            if (send_in || (pend_q && rcnt_q == 8'h00)) begin
                rx_valid_out <= 1'b1;
                rx_data_out  <= reply_data_in;
                pend_q       <= 1'b0;
            end else if (pend_q) begin
                rcnt_q <= rcnt_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: test_can_link_pingpong_tester.sv
`timescale 1ns/1ps
`default_nettype none
`include "pingpong_consts.vh"
module test_can_link_pingpong_tester;
    logic        clk_sys_in, rst_in, pat_s, role_s, rhi_s, rlo_s, boot_a, boot_b, prev;
    logic        tx_done, rx_valid, ctrl_err, bus_off, reg_wr, reg_rd, reply_en, send;
    logic        nvm, cfg_valid, tx_req, err_led, bo_led, m_led, irq;
    logic [31:0] rx_data, reply_data, reg_wdata, reg_rdata, rd_val, tx_data;
    logic [7:0]  reg_addr, delay;
    logic [1:0]  rate_sel;
    logic [15:0] e0;
    int          failures, n_compared, i, k, rises;
    wire  [4:0]  watch = {irq, bo_led, err_led, tx_req, cfg_valid};

    // short counts keep the run small
    can_link_pingpong_tester #(.TIMEOUT_CYCLES(32'd200), .BLINK_HALF_CYCLES(32'd20)) DUT (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .pattern_select_strap_in(pat_s),
        .role_select_strap_in(role_s), .rate_strap_high_in(rhi_s), .rate_strap_low_in(rlo_s),
        .boot_strap_a_in(boot_a), .boot_strap_b_in(boot_b), .boot_from_nvm_out(nvm),
        .can_cfg_valid_out(cfg_valid), .can_rate_sel_out(rate_sel), .tx_req_out(tx_req),
        .tx_data_out(tx_data), .tx_done_in(tx_done), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
        .ctrl_error_in(ctrl_err), .ctrl_bus_off_in(bus_off), .error_led_out(err_led),
        .bus_off_led_out(bo_led), .master_led_out(m_led), .irq_out(irq), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
    can_ctrl_model u_bus (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .tx_req_in(tx_req), .reply_en_in(reply_en),
        .reply_data_in(reply_data), .delay_in(delay), .send_in(send), .tx_done_out(tx_done),
        .rx_valid_out(rx_valid), .rx_data_out(rx_data));

    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask

    // data stand one cycle after the strobe
    task reg_read(input logic [7:0] a);
        @(posedge clk_sys_in);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task wait_hi(input int sel);
        for (k = 0; k < 600 && watch[sel] !== 1'b1; k++) begin
            @(posedge clk_sys_in);
            #1;
        end
        check(watch[sel], 1'b1, "awaited output");
    endtask

    // power cycle: straps first, reset held 20 clocks
    task start(input logic [3:0] cfg, input logic ba, input logic bb);
        {role_s, pat_s, rhi_s, rlo_s} <= cfg; boot_a <= ba; boot_b <= bb; rst_in <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        wait_hi(0);
    endtask

    task end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {pat_s, role_s, rhi_s, rlo_s, boot_a, boot_b, ctrl_err, bus_off, reg_wr, reg_rd} = 10'h000;
        {reply_en, send, rst_in} = 3'b001; reply_data = 32'h0; reg_wdata = 32'h0;
        reg_addr = 8'h00; delay = 8'h14; failures = 0; n_compared = 0;
        // all sixteen strap settings
        for (i = 0; i < 16; i++) begin
            start(i[3:0], i[2], i[3]);
            check(rate_sel, i[1:0], "rate select");
            check(nvm, i[2] & i[3], "boot source");
            reg_read(`REG_CONFIG);
            check(rd_val, {26'h0, 1'b1, i[2] & i[3], i[1], i[0], i[2], i[3]}, "config");
            repeat (2) @(posedge clk_sys_in);
            #1 check({tx_req, m_led}, {2{i[3]}}, "role");
        end
        // master, prompt partner; straps moved late
        delay <= 8'h03; reply_en <= 1'b1; reply_data <= 32'h55555555;
        start(4'hA, 1'b1, 1'b1);
        @(posedge clk_sys_in);
        {role_s, pat_s, rhi_s, rlo_s} <= 4'h5;
        wait_hi(1);
        check(tx_data, 32'h55555555, "master payload");
        repeat (60) @(posedge clk_sys_in);
        #1 check(rate_sel, 2'h2, "rate kept");
        reg_write(`REG_CONFIG, 32'h0);
        reg_read(`REG_CONFIG);
        check(rd_val, 32'h39, "config kept");
        reg_read(`REG_STATUS);
        check(rd_val[5:0], 6'h30, "clean traffic");
        reg_write(`REG_STATUS, 32'h3F);
        reg_read(`REG_ERR_COUNT);
        e0 = rd_val[15:0];
        reply_data <= 32'h55555554;
        wait_hi(2);
        reply_data <= 32'h55555555;
        reg_read(`REG_STATUS);
        check(rd_val[1], 1'b1, "mismatch flag");
        check(irq, 1'b0, "masked irq");
        reg_read(`REG_ERR_COUNT);
        check(rd_val[15:0] > e0, 1'b1, "error count");
        // silent partner
        reply_en <= 1'b0;
        reg_write(`REG_MASK, 32'h01);
        wait_hi(4);
        wait_hi(1);
        reg_write(`REG_STATUS, 32'h01);
        repeat (2) @(posedge clk_sys_in);
        #1 check(irq, 1'b0, "irq cleared");
        reg_write(`REG_CONTROL, 32'h01);
        reg_read(`REG_ERR_COUNT);
        check(rd_val, 32'h0, "counts cleared");
        reg_read(8'h3C);
        check(rd_val, 32'h0, "unmapped read");
        // slave with a slow partner
        delay <= 8'h10; reply_data <= 32'h0;
        start(4'h5, 1'b0, 1'b0);
        repeat (300) @(posedge clk_sys_in);
        #1 check(tx_req, 1'b0, "slave quiet");
        reg_read(`REG_STATUS);
        check(rd_val[0], 1'b0, "no early timeout");
        send <= 1'b1;
        @(posedge clk_sys_in);
        send <= 1'b0;
        wait_hi(1);
        check(tx_data, 32'h0, "slave reply payload");
        wait_hi(2);
        rises = 1;
        prev = 1'b1;
        for (k = 0; k < 170; k++) begin
            @(posedge clk_sys_in);
            #1;
            if (err_led && !prev) rises++;
            prev = err_led;
        end
        check(rises, 4, "blink count");
        bus_off <= 1'b1;
        wait_hi(3);
        ctrl_err <= 1'b1; send <= 1'b1;
        @(posedge clk_sys_in);
        send <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        reg_read(`REG_STATUS);
        check(rd_val[3:2], 2'h3, "controller flags");
        end_sim;
    end

    // tests take about 1800 clocks
    initial begin
        #200000;
        failures++;
        end_sim;
    end
endmodule
`default_nettype wire
